// file: rtl/outprot_pkg.sv
// constants, register map and types for the output protection and run/stop block
// assumes one 100 MHz system clock and a 32-bit Avalon-MM register bus
package outprot_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 5;
   localparam int CLUSTER_SIZE = 4;
   localparam int MAX_CLUSTERS = 4;
   localparam int SEL_W = 5;
   localparam int IRQ_W = MAX_CLUSTERS + 1;
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_MS = 1000000;
   localparam int REARM_PERIOD_MS = 1000;
   localparam int REARM_CYCLES_DEF = REARM_PERIOD_MS * (NS_PER_MS / CLK_PERIOD_NS);
   // byte offsets, one aligned word each
   localparam logic [ADDR_W-1:0] CTRL_OFS = 5'h00;
   localparam logic [ADDR_W-1:0] CMD_OFS = 5'h04;
   localparam logic [ADDR_W-1:0] APP_OFS = 5'h08;
   localparam logic [ADDR_W-1:0] DFLT_OFS = 5'h0c;
   localparam logic [ADDR_W-1:0] FSEL_OFS = 5'h10;
   localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h14;
   localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 5'h18;
   localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 5'h1c;
   // field positions
   localparam int CTRL_INHIBIT_BIT = 0;
   localparam int CTRL_SEL_EN_BIT = 1;
   localparam int CTRL_SEL_LSB = 8;
   localparam int CMD_RUN_BIT = 0;
   localparam int CMD_STOP_BIT = 1;
   localparam int STATUS_RUN_BIT = 0;
   localparam int STATUS_FAULT_LSB = 8;
   localparam int IRQ_STATE_BIT = 4;
   // reset values
   localparam logic [DATA_W-1:0] APP_RST = 32'h0;
   localparam logic [DATA_W-1:0] DFLT_RST = 32'h0;
   localparam logic [DATA_W-1:0] FSEL_RST = 32'h0;
   localparam logic [IRQ_W-1:0] IRQ_RST = 5'h0;
   typedef enum logic {halted_state, run_state} run_type;
   typedef struct packed {
      logic read;
      logic write;
      logic [ADDR_W-1:0] address;
      logic [DATA_W-1:0] writedata;
   } av_req_type;
   typedef struct packed {
      logic [SEL_W-1:0] in_sel;
      logic in_en;
      logic inhibit;
   } ctrl_type;
   localparam ctrl_type CTRL_RST = '{in_sel: 5'h0, in_en: 1'b0, inhibit: 1'b0};
endpackage

// file: rtl/output_protect_run_stop.sv
// output stage (function select, fallback, cluster protection) and run/stop arbitration
// assumes pins arrive asynchronously; function engines run on clk_in
// Function
// R01: outputs selectable to special function sources
// R02: unassigned outputs follow application value
// R03: halted state drives configured default values
// R04: protection clusters of four outputs
// R05: fault forces whole cluster to zero
// R06: periodic automatic rearm about one second
// R07: inhibit setting keeps tripped cluster off
// R08: short to low rail trips automatically
// R09: short to high rail: no action
// R10: relay outputs never trip nor report
// R11: three run/stop sources arbitrated
// R12: switch positions select run or halt
// R13: switch stop overrides input and software
// R14: switch rise runs unless input low
// R15: software commands accepted when input permits
// R16: input rise runs, input low halts
// R17: only one input selectable for run/stop
// R18: rearm rechecks fault, restarts timer
// R19: per-cluster fault flag in status
//
// The implementer's own choices: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
module output_protect_run_stop #(
   parameter int NUM_OUT = 16,
   parameter int NUM_IN = 24,
   parameter logic [NUM_OUT-1:0] TRANSISTOR_MASK = '1,
   parameter logic [NUM_OUT-1:0] FUNC_CAPABLE = '1,
   parameter int REARM_CYCLES = outprot_pkg::REARM_CYCLES_DEF
) (
   input wire logic clk_in, // system clock
   input wire logic rst_n_in, // async reset, low
   input wire outprot_pkg::av_req_type av_in, // avalon request
   output logic [outprot_pkg::DATA_W-1:0] av_readdata_out, // avalon read data
   output logic av_waitrequest_out, // avalon wait
   input wire logic run_switch_in, // panel switch, 1 = run
   input wire logic [NUM_IN-1:0] field_in, // digital field inputs
   input wire logic [NUM_OUT-1:0] fault_in, // overcurrent detectors
   input wire logic [NUM_OUT-1:0] func_value_in, // function engine values
   output logic [NUM_OUT-1:0] drive_out, // output stage drive
   output logic running_out, // controller in run
   output logic irq_out // interrupt, high level
);
   import outprot_pkg::*;
   // R04 cluster count
   localparam int NUM_CL = (NUM_OUT + CLUSTER_SIZE - 1) / CLUSTER_SIZE;
   localparam int CNT_W = $clog2(REARM_CYCLES + 1);
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(REARM_CYCLES - 1);
   localparam int SYNC_W = NUM_IN + NUM_OUT + 1;
   // R04 cluster membership
   function automatic logic cluster_any(input logic [NUM_OUT-1:0] v, input int c);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_OUT; i++)
      begin
         if (i / CLUSTER_SIZE == c)
            r = r | v[i];
      end
      return r;
   endfunction
   logic [1:0] rst_sync;
   logic rst_n, sw;
   logic [SYNC_W-1:0] sync_a, sync_b;
   logic [NUM_IN-1:0] field;
   logic [NUM_OUT-1:0] fault;
   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         rst_sync <= 2'h0;
      else
         rst_sync <= {rst_sync[0], 1'b1};
   end
   assign rst_n = rst_sync[1];
   // sync_a feeds only sync_b
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
         {sync_b, sync_a} <= '0;
      else
         {sync_b, sync_a} <= {sync_a, run_switch_in, field_in, fault_in};
   end
   assign sw = sync_b[SYNC_W-1];
   assign field = sync_b[NUM_OUT +: NUM_IN];
   assign fault = sync_b[NUM_OUT-1:0];
   // register bus and registers
   ctrl_type ctrl, next_ctrl;
   logic [NUM_OUT-1:0] app, next_app, dflt, next_dflt, fsel, next_fsel;
   logic [IRQ_W-1:0] irq_stat, next_irq_stat, irq_mask, next_irq_mask, events;
   logic ack, next_ack, cmd_run, next_cmd_run, cmd_stop, next_cmd_stop;
   logic [DATA_W-1:0] next_rdata, rd_mux;
   logic wr_now;
   logic [NUM_CL-1:0] tripped;
   run_type state, next_state;
   assign wr_now = av_in.write & ack;
   assign av_waitrequest_out = (av_in.read | av_in.write) & ~ack;
   assign irq_out = |(irq_stat & irq_mask);
   always_comb
   begin
      rd_mux = '0;
      case (av_in.address)
         CTRL_OFS:
         begin
            rd_mux[CTRL_INHIBIT_BIT] = ctrl.inhibit;
            rd_mux[CTRL_SEL_EN_BIT] = ctrl.in_en;
            rd_mux[CTRL_SEL_LSB +: SEL_W] = ctrl.in_sel;
         end
         APP_OFS: rd_mux[NUM_OUT-1:0] = app;
         DFLT_OFS: rd_mux[NUM_OUT-1:0] = dflt;
         FSEL_OFS: rd_mux[NUM_OUT-1:0] = fsel;
         STATUS_OFS:
         begin
            rd_mux[STATUS_RUN_BIT] = (state == run_state);
            // R19 fault flags
            rd_mux[STATUS_FAULT_LSB +: NUM_CL] = tripped;
         end
         IRQ_STAT_OFS: rd_mux[IRQ_W-1:0] = irq_stat;
         IRQ_MASK_OFS: rd_mux[IRQ_W-1:0] = irq_mask;
         default: rd_mux = '0;
      endcase
   end
   always_comb
   begin
      next_ack = (av_in.read | av_in.write) & ~ack;
      next_rdata = ack ? av_readdata_out : rd_mux;
      next_ctrl = ctrl;
      next_app = app;
      next_dflt = dflt;
      next_fsel = fsel;
      next_irq_mask = irq_mask;
      next_cmd_run = 1'b0;
      next_cmd_stop = 1'b0;
      // set wins over write-one-to-clear
      next_irq_stat = irq_stat | events;
      if (wr_now)
      begin
         case (av_in.address)
            CTRL_OFS:
            begin
               next_ctrl.inhibit = av_in.writedata[CTRL_INHIBIT_BIT];
               next_ctrl.in_en = av_in.writedata[CTRL_SEL_EN_BIT];
               // R17 single input index
               next_ctrl.in_sel = av_in.writedata[CTRL_SEL_LSB +: SEL_W];
            end
            CMD_OFS:
            begin
               next_cmd_run = av_in.writedata[CMD_RUN_BIT];
               next_cmd_stop = av_in.writedata[CMD_STOP_BIT];
            end
            APP_OFS: next_app = av_in.writedata[NUM_OUT-1:0];
            DFLT_OFS: next_dflt = av_in.writedata[NUM_OUT-1:0];
            FSEL_OFS: next_fsel = av_in.writedata[NUM_OUT-1:0];
            IRQ_STAT_OFS:
               next_irq_stat = (irq_stat & ~av_in.writedata[IRQ_W-1:0]) | events;
            IRQ_MASK_OFS: next_irq_mask = av_in.writedata[IRQ_W-1:0];
            default: next_ctrl = ctrl;
         endcase
      end
   end
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack <= 1'b0;
         av_readdata_out <= '0;
         ctrl <= CTRL_RST;
         app <= APP_RST[NUM_OUT-1:0];
         dflt <= DFLT_RST[NUM_OUT-1:0];
         fsel <= FSEL_RST[NUM_OUT-1:0];
         irq_stat <= IRQ_RST;
         irq_mask <= IRQ_RST;
         cmd_run <= 1'b0;
         cmd_stop <= 1'b0;
      end
      else
      begin
         ack <= next_ack;
         av_readdata_out <= next_rdata;
         ctrl <= next_ctrl;
         app <= next_app;
         dflt <= next_dflt;
         fsel <= next_fsel;
         irq_stat <= next_irq_stat;
         irq_mask <= next_irq_mask;
         cmd_run <= next_cmd_run;
         cmd_stop <= next_cmd_stop;
      end
   end
   // run/stop arbitration
   logic sw_d, inp, inp_d, sel_ok, sw_rise, inp_rise, force_stop, go, drop;
   assign sel_ok = ctrl.in_en && (ctrl.in_sel < NUM_IN);
   // out-of-range index reads low; sel_ok masks it anyway
   assign inp = (ctrl.in_sel < NUM_IN) ? field[ctrl.in_sel] : 1'b0;
   assign sw_rise = sw & ~sw_d;
   assign inp_rise = inp & ~inp_d;
   always_comb
   begin
      // R12 R13 switch stop, or R16 input low
      force_stop = !sw || (sel_ok && !inp);
      // R11 R14 R15 R16 sources that start the program
      go = !force_stop && (sw_rise || (sel_ok && inp_rise) || (cmd_run && !cmd_stop));
      // R15 software stop
      drop = force_stop || (cmd_stop && !(sel_ok && inp_rise));
      next_state = state;
      case (state)
         halted_state:
         begin
            if (go)
               next_state = run_state;
         end
         run_state:
         begin
            if (drop)
               next_state = halted_state;
         end
         default: next_state = halted_state;
      endcase
   end
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= halted_state;
         sw_d <= 1'b0;
         inp_d <= 1'b0;
      end
      else
      begin
         state <= next_state;
         sw_d <= sw;
         inp_d <= inp;
      end
   end
   assign running_out = (state == run_state);
   // cluster protection
   logic [NUM_CL-1:0] next_tripped, fault_cl, trip_ev;
   logic [CNT_W-1:0] cnt [NUM_CL], next_cnt [NUM_CL];
   logic [NUM_OUT-1:0] keep, fmask, next_drive;
   always_comb
   begin
      for (int c = 0; c < NUM_CL; c++)
      begin
         // R08 short to 0 V seen as overcurrent
         // R09 no detector for short to 24 V
         // R10 relay positions masked out
         fault_cl[c] = cluster_any(fault & TRANSISTOR_MASK, c);
         next_tripped[c] = tripped[c];
         next_cnt[c] = cnt[c];
         trip_ev[c] = 1'b0;
         if (!tripped[c])
         begin
            // R05 trip whole cluster
            if (fault_cl[c])
            begin
               next_tripped[c] = 1'b1;
               next_cnt[c] = '0;
               trip_ev[c] = 1'b1;
            end
         end
         // R07 inhibit freezes the timer
         else if (!ctrl.inhibit)
         begin
            // R06 R18 rearm attempt rechecks fault
            if (cnt[c] == CNT_LAST)
            begin
               next_cnt[c] = '0;
               if (!fault_cl[c])
                  next_tripped[c] = 1'b0;
            end
            else
               next_cnt[c] = cnt[c] + CNT_W'(1);
         end
      end
      events = '0;
      events[NUM_CL-1:0] = trip_ev;
      events[IRQ_STATE_BIT] = (next_state != state);
   end
   always_comb
   begin
      for (int i = 0; i < NUM_OUT; i++)
         keep[i] = ~tripped[i / CLUSTER_SIZE];
      // R01 only capable outputs take a function
      fmask = fsel & FUNC_CAPABLE;
      // R02 plain outputs follow application
      next_drive = (func_value_in & fmask) | (app & ~fmask);
      // R03 fallback while halted
      if (state == halted_state)
         next_drive = dflt;
      // R05 tripped clusters at zero
      next_drive = next_drive & keep;
   end
   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tripped <= '0;
         drive_out <= '0;
         for (int c = 0; c < NUM_CL; c++)
            cnt[c] <= '0;
      end
      else
      begin
         tripped <= next_tripped;
         drive_out <= next_drive;
         for (int c = 0; c < NUM_CL; c++)
            cnt[c] <= next_cnt[c];
      end
   end
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n);
   property p_switch_stop;
      !sw |=> state == halted_state;
   endproperty
   a_switch_stop: assert property (p_switch_stop) else $error("switch stop not halted"); // R13
   property p_input_low;
      sw && sel_ok && !inp |=> state == halted_state;
   endproperty
   a_input_low: assert property (p_input_low) else $error("low input not halted"); // R16
   property p_switch_rise;
      sw_rise && !sel_ok |=> state == run_state;
   endproperty
   a_switch_rise: assert property (p_switch_rise) else $error("switch rise no run"); // R14
   property p_soft_stop;
      sw && !sw_rise && !sel_ok && cmd_stop |=> state == halted_state;
   endproperty
   a_soft_stop: assert property (p_soft_stop) else $error("software stop ignored"); // R15
   property p_halt_default;
      state == halted_state |=> drive_out == ($past(dflt) & $past(keep));
   endproperty
   a_halt_default: assert property (p_halt_default) else $error("default not driven"); // R03
   property p_regular;
      state == run_state && fsel == '0 |=> drive_out == ($past(app) & $past(keep));
   endproperty
   a_regular: assert property (p_regular) else $error("regular output wrong"); // R02

   for (genvar g = 0; g < NUM_CL; g++)
   begin : g_chk
      sequence s_due;
         tripped[g] && !ctrl.inhibit && cnt[g] == CNT_LAST;
      endsequence
      sequence s_new_fault;
         !tripped[g] && fault_cl[g];
      endsequence
      property p_trip;
         s_new_fault |=> tripped[g] ##1 !cluster_any(drive_out, g);
      endproperty
      a_trip: assert property (p_trip) else $error("cluster not shut down"); // R05
      property p_rearm;
         (s_due ##0 !fault_cl[g]) |=> !tripped[g];
      endproperty
      a_rearm: assert property (p_rearm) else $error("cluster not rearmed"); // R06
      property p_retrip;
         (s_due ##0 fault_cl[g]) |=> tripped[g] && cnt[g] == '0;
      endproperty
      a_retrip: assert property (p_retrip) else $error("persistent fault rearmed"); // R18
      property p_inhibit;
         tripped[g] && ctrl.inhibit |=> tripped[g] && cnt[g] == $past(cnt[g]);
      endproperty
      a_inhibit: assert property (p_inhibit) else $error("inhibited cluster rearmed"); // R07
      property p_flag;
         $fell(tripped[g]) |-> $past(cnt[g]) == CNT_LAST && !$past(fault_cl[g]);
      endproperty
      a_flag: assert property (p_flag) else $error("fault flag cleared early"); // R19
   end
endmodule

// file: testbench/field_side_model.sv
// far side of the block: panel switch, field lines, function engines, detectors
// assumes the bench sets the wanted conditions between clock edges
`timescale 1ns/100ps
module field_side_model (
   input wire logic clk_in, // system clock
   input wire logic switch_req_in, // wanted switch position, 1 = run
   input wire logic [23:0] field_req_in, // wanted field levels
   input wire logic [15:0] short_low_in, // outputs shorted to the low rail
   input wire logic [15:0] func_req_in, // wanted function engine values
   output logic run_switch_out, // switch contact
   output logic [23:0] field_out, // field input lines
   output logic [15:0] fault_out, // overcurrent detector flags
   output logic [15:0] func_out // function engine values
);
   // outputs unknown until the first edge, well inside the bench's reset
   always @(posedge clk_in)
   begin
      run_switch_out <= switch_req_in;
      field_out <= field_req_in;
      func_out <= func_req_in;
      // low short only
      // detector keeps flagging while the cluster is off, as a real sensor would
      fault_out <= short_low_in;
   end
endmodule

// file: testbench/output_protect_run_stop_tb_top.sv
// self-checking bench for the output stage and run/stop arbitration
// assumes upper cluster wired to relays and only the lower byte function capable
`timescale 1ns/100ps
module output_protect_run_stop_tb_top;
   import outprot_pkg::*;
   localparam int REARM = 30;
   logic clk_in, rst_n_in, sw, run_switch, running_out, irq_out, av_waitrequest_out;
   logic [23:0] fld, field;
   logic [15:0] short_lo, func, fault, func_value, drive_out;
   logic [31:0] rdata, q;
   av_req_type av;
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   output_protect_run_stop #(.TRANSISTOR_MASK(16'h0fff), .FUNC_CAPABLE(16'h00ff),
      .REARM_CYCLES(REARM)) uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .av_in(av),
      .av_readdata_out(rdata), .av_waitrequest_out(av_waitrequest_out),
      .run_switch_in(run_switch), .field_in(field), .fault_in(fault),
      .func_value_in(func_value), .drive_out(drive_out), .running_out(running_out),
      .irq_out(irq_out));
   field_side_model partner (.clk_in(clk_in), .switch_req_in(sw), .field_req_in(fld),
      .short_low_in(short_lo), .func_req_in(func), .run_switch_out(run_switch),
      .field_out(field), .fault_out(fault), .func_out(func_value));
   task automatic summarize;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // request held until waitrequest is sampled low at a rising edge, released at that edge
   task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_in);
      av <= '{read: rd, write: !rd, address: a, writedata: d};
      @(posedge clk_in);
      while (av_waitrequest_out !== 1'b0)
         @(posedge clk_in);
      q = rdata;
      av <= '{read: 1'b0, write: 1'b0, address: a, writedata: d};
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      bus(1'b0, a, d);
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
      bus(1'b1, a, 32'h0);
      check("register", q, exp);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      @(negedge clk_in);
   endtask
   task automatic t_reset;
      @(negedge clk_in);
      check("drive", 32'(drive_out), 32'h0);
      check("running", 32'(running_out), 32'h0);
      for (int i = 0; i < 8; i++)
         rdchk(5'(i * 4), 32'h0);
      rdchk(5'h01, 32'h0);
   endtask
   task automatic t_halt;
      wr(DFLT_OFS, 32'h0000a5c3);
      wr(APP_OFS, 32'h00001234);
      wr(5'h01, 32'hffffffff);
      wr(CMD_OFS, 32'h1);
      settle(6);
      check("running", 32'(running_out), 32'h0);
      check("drive", 32'(drive_out), 32'h0000a5c3);
      rdchk(APP_OFS, 32'h00001234);
   endtask
   task automatic t_run;
      sw <= 1'b1;
      settle(8);
      check("running", 32'(running_out), 32'h1);
      check("drive", 32'(drive_out), 32'h00001234);
      rdchk(STATUS_OFS, 32'h1);
      func <= 16'h0f0f;
      wr(FSEL_OFS, 32'h0000ffff);
      settle(4);
      check("drive", 32'(drive_out), 32'h0000120f);
      wr(FSEL_OFS, 32'h0);
   endtask
   task automatic t_soft_irq;
      wr(IRQ_STAT_OFS, 32'h1f);
      wr(CMD_OFS, 32'h2);
      settle(4);
      check("running", 32'(running_out), 32'h0);
      check("drive", 32'(drive_out), 32'h0000a5c3);
      check("irq", 32'(irq_out), 32'h0);
      rdchk(IRQ_STAT_OFS, 32'h10);
      wr(IRQ_MASK_OFS, 32'h10);
      settle(1);
      check("irq", 32'(irq_out), 32'h1);
      wr(IRQ_STAT_OFS, 32'h10);
      settle(1);
      check("irq", 32'(irq_out), 32'h0);
      wr(CMD_OFS, 32'h3);
      settle(4);
      check("running", 32'(running_out), 32'h0);
      wr(CMD_OFS, 32'h1);
      settle(4);
      check("running", 32'(running_out), 32'h1);
   endtask
   task automatic t_input;
      wr(CTRL_OFS, 32'h00000302);
      settle(6);
      check("running", 32'(running_out), 32'h0);
      wr(CMD_OFS, 32'h1);
      fld[4] <= 1'b1;
      settle(6);
      check("running", 32'(running_out), 32'h0);
      fld[3] <= 1'b1;
      settle(6);
      check("running", 32'(running_out), 32'h1);
      fld[3] <= 1'b0;
      settle(6);
      check("running", 32'(running_out), 32'h0);
      sw <= 1'b0;
      settle(1);
      fld[3] <= 1'b1;
      settle(6);
      check("running", 32'(running_out), 32'h0);
      sw <= 1'b1;
      settle(6);
      check("running", 32'(running_out), 32'h1);
      sw <= 1'b0;
      fld[3] <= 1'b0;
      settle(6);
      sw <= 1'b1;
      settle(6);
      check("running", 32'(running_out), 32'h0);
      wr(CTRL_OFS, 32'h0);
      wr(CMD_OFS, 32'h1);
      settle(4);
      check("running", 32'(running_out), 32'h1);
   endtask
   task automatic t_trip;
      wr(APP_OFS, 32'h0000ffff);
      wr(IRQ_STAT_OFS, 32'h1f);
      short_lo <= 16'h0020;
      settle(6);
      check("drive", 32'(drive_out), 32'h0000ff0f);
      rdchk(STATUS_OFS, 32'h201);
      rdchk(IRQ_STAT_OFS, 32'h02);
      settle(REARM + 10);
      check("drive", 32'(drive_out), 32'h0000ff0f);
      short_lo <= 16'h0;
      settle(REARM + 6);
      check("drive", 32'(drive_out), 32'h0000ffff);
      rdchk(STATUS_OFS, 32'h1);
   endtask
   task automatic t_inhibit;
      wr(CTRL_OFS, 32'h1);
      short_lo <= 16'h0001;
      settle(5);
      short_lo <= 16'h0;
      settle(3 * REARM);
      check("drive", 32'(drive_out), 32'h0000fff0);
      wr(CTRL_OFS, 32'h0);
      settle(REARM + 6);
      check("drive", 32'(drive_out), 32'h0000ffff);
   endtask
   task automatic t_relay;
      short_lo <= 16'hf000;
      settle(REARM);
      check("drive", 32'(drive_out), 32'h0000ffff);
      rdchk(STATUS_OFS, 32'h1);
      short_lo <= 16'h0;
   endtask
   initial
   begin
      clk_in = 1'b0;
      forever #5 clk_in = ~clk_in;
   end
   initial
   begin
      rst_n_in = 1'b0;
      av = '0;
      sw = 1'b0;
      fld = 24'h0;
      short_lo = 16'h0;
      func = 16'h0;
      repeat (6) @(posedge clk_in);
      rst_n_in <= 1'b1;
      repeat (5) @(posedge clk_in);
      t_reset;
      t_halt;
      t_run;
      t_soft_irq;
      t_input;
      t_trip;
      t_inhibit;
      t_relay;
      summarize;
   end
   // hang guard, well above the few hundred cycles the sequence needs
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 8000)
      begin
         fail_count++;
         summarize;
      end
   end
endmodule
